// *** core/wake_int_pkg.sv ***
// Shared constants and carrier types of the wake interrupt and measure gate block.
package wake_int_pkg;

   localparam int CLK_HZ = 20000000;
   localparam int SHORT_FILTER_US = 16;
   localparam int LONG_FILTER_US = 64;
   localparam int PULSE_TIME_US = 100;
   localparam int GAP_TIME_US = 100;
   localparam int SHORT_FILTER_CYC = SHORT_FILTER_US * (CLK_HZ / 1000000);
   localparam int LONG_FILTER_CYC = LONG_FILTER_US * (CLK_HZ / 1000000);
   localparam int PULSE_CYC = PULSE_TIME_US * (CLK_HZ / 1000000);
   localparam int GAP_CYC = GAP_TIME_US * (CLK_HZ / 1000000);
   localparam int CNT_W = 12;

   localparam int NUM_WAKE = 3;
   localparam int NUM_GPIO_WAKE = 2;
   localparam int NUM_FAIL = 8;

   localparam logic [1:0] PULL_NONE = 2'h0;
   localparam logic [1:0] PULL_DOWN = 2'h1;
   localparam logic [1:0] PULL_UP = 2'h2;
   localparam logic [1:0] PULL_AUTO = 2'h3;

   localparam logic [1:0] FILT_STATIC_SHORT = 2'h0;
   localparam logic [1:0] FILT_STATIC_LONG = 2'h1;

   localparam logic [2:0] CMD_NONE = 3'h0;
   localparam logic [2:0] CMD_NORMAL = 3'h1;
   localparam logic [2:0] CMD_STOP = 3'h2;
   localparam logic [2:0] CMD_SLEEP = 3'h3;

   typedef enum logic [4:0] {
      MODE_INIT = 5'h01,
      MODE_NORMAL = 5'h02,
      MODE_STOP = 5'h04,
      MODE_SLEEP = 5'h08,
      MODE_RESTART = 5'h10
   } sbc_mode_e;

   typedef enum logic [2:0] {
      INT_IDLE = 3'h1,
      INT_PULSE = 3'h2,
      INT_GAP = 3'h4
   } int_state_e;

   typedef struct packed {
      logic [1:0] pull;
      logic [1:0] filter;
      logic wakeEnable;
   } wake_cfg_s;

   typedef struct packed {
      logic [NUM_WAKE-1:0] wakeA;
      logic [NUM_GPIO_WAKE-1:0] wakeB;
      logic [NUM_WAKE-1:0] level;
      logic [NUM_FAIL-1:0] fail;
   } status_s;

endpackage

// *** core/wake_filter.sv ***
// Static sense edge filter for one wake input.
`timescale 1ns/1ps
`default_nettype none
module wake_filter (
   input wire logic clk,
   input wire logic rst,
   input wire logic pinIn,
   input wire logic gate,
   input wire logic longSel,
   output logic level,
   output logic edgeSeen
);

   typedef struct packed {
      logic stable;
      logic cand;
      logic [wake_int_pkg::CNT_W-1:0] cnt;
      logic hit;
   } filt_s;

   filt_s cur;
   filt_s next_cur;
   logic [wake_int_pkg::CNT_W-1:0] limit;

   always_comb begin
      limit = longSel ? wake_int_pkg::CNT_W'(wake_int_pkg::LONG_FILTER_CYC)
                      : wake_int_pkg::CNT_W'(wake_int_pkg::SHORT_FILTER_CYC);
      next_cur = cur;
      next_cur.hit = 1'b0;
      if (gate) begin
         next_cur.cand = cur.stable;
         next_cur.cnt = '0;
      end else if (pinIn != cur.cand) begin
         next_cur.cand = pinIn;
         next_cur.cnt = '0;
      end else if (cur.cand != cur.stable) begin
         if (cur.cnt + 1'b1 >= limit) begin
            next_cur.stable = cur.cand;
            next_cur.hit = 1'b1;
            next_cur.cnt = '0;
         end else begin
            next_cur.cnt = cur.cnt + 1'b1;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cur <= '0;
      end else begin
         cur <= next_cur;
      end
   end

   assign level = cur.stable;
   assign edgeSeen = cur.hit;

endmodule
`default_nettype wire

// *** core/wake_interrupt_and_measure_gate.sv ***
// Interrupt pulse generator with wake status latching and measurement-mode gating.
`timescale 1ns/1ps
`default_nettype none
module wake_interrupt_and_measure_gate (
   input wire logic clk,
   input wire logic rst,
   input wire logic [wake_int_pkg::NUM_WAKE-1:0] wakePin,
   input wire logic [wake_int_pkg::NUM_GPIO_WAKE-1:0] gpioWakeEvent,
   input wire logic [wake_int_pkg::NUM_GPIO_WAKE-1:0] gpioWakeEnable,
   input wire wake_int_pkg::wake_cfg_s [wake_int_pkg::NUM_WAKE-1:0] wakeCfg,
   input wire logic voltageMeasureEnable,
   input wire logic interruptClassSelect,
   input wire logic [wake_int_pkg::NUM_FAIL-1:0] failEvent,
   input wire logic [wake_int_pkg::NUM_FAIL-1:0] failIntCapable,
   input wire logic [2:0] modeCommand,
   input wire logic initDone,
   input wire logic clearWakeA,
   input wire logic clearWakeB,
   input wire logic clearFail,
   input wire logic interruptPinIn,
   output logic interruptOutput,
   output logic interruptOutputEnable,
   output logic measurePathSwitch,
   output logic [wake_int_pkg::NUM_WAKE-1:0] pullUpOn,
   output logic [wake_int_pkg::NUM_WAKE-1:0] pullDownOn,
   output wake_int_pkg::status_s statusRead,
   output logic commandFaultFlag,
   output wake_int_pkg::sbc_mode_e sbcMode,
   output logic configSelect
);

   typedef struct packed {
      wake_int_pkg::sbc_mode_e mode;
      wake_int_pkg::int_state_e intState;
      logic [wake_int_pkg::CNT_W-1:0] timer;
      wake_int_pkg::status_s live;
      wake_int_pkg::status_s snap;
      logic intPending;
      logic intLine;
      logic intDrive;
      logic switchOn;
      logic [wake_int_pkg::NUM_WAKE-1:0] pu;
      logic [wake_int_pkg::NUM_WAKE-1:0] pd;
      logic cmdFault;
      logic cfgSel;
   } state_s;

   state_s cur;
   state_s next_cur;
   logic [wake_int_pkg::NUM_WAKE-1:0] gated;
   logic [wake_int_pkg::NUM_WAKE-1:0] filtLevel;
   logic [wake_int_pkg::NUM_WAKE-1:0] filtEdge;

   function automatic logic isMeasured(input int idx);
      isMeasured = (idx < 2);
   endfunction

   // True in the modes in which an interrupt pulse may be signalled.
   function automatic logic isActiveMode(input wake_int_pkg::sbc_mode_e m);
      isActiveMode = (m == wake_int_pkg::MODE_NORMAL) || (m == wake_int_pkg::MODE_STOP);
   endfunction

   // True on the last cycle of a stretch that lasts cyc cycles.
   function automatic logic timerDone(input logic [wake_int_pkg::CNT_W-1:0] t, input int cyc);
      timerDone = (t >= wake_int_pkg::CNT_W'(cyc - 1));
   endfunction

   // True when the first two pins are the only enabled wake sources.
   function automatic logic onlyMeasured(
      input wake_int_pkg::wake_cfg_s [wake_int_pkg::NUM_WAKE-1:0] cfg,
      input logic [wake_int_pkg::NUM_GPIO_WAKE-1:0] gpioEn
   );
      logic measEn;
      logic otherEn;
      measEn = cfg[0].wakeEnable || cfg[1].wakeEnable;
      otherEn = cfg[2].wakeEnable || (|gpioEn);
      onlyMeasured = measEn && !otherEn;
   endfunction

   genvar gi;
   generate
      for (gi = 0; gi < wake_int_pkg::NUM_WAKE; gi++) begin : g_wake
         assign gated[gi] = voltageMeasureEnable && isMeasured(gi);
         wake_filter u_filt (
            .clk(clk),
            .rst(rst),
            .pinIn(wakePin[gi]),
            .gate(gated[gi]),
            .longSel(wakeCfg[gi].filter == wake_int_pkg::FILT_STATIC_LONG),
            .level(filtLevel[gi]),
            .edgeSeen(filtEdge[gi])
         );
      end
   endgenerate

   always_comb begin
      logic [wake_int_pkg::NUM_WAKE-1:0] wkEn;
      logic anyWake;
      logic intEvent;
      logic onlyMeasSrc;
      wkEn = '0;
      anyWake = 1'b0;
      intEvent = 1'b0;
      onlyMeasSrc = 1'b0;
      next_cur = cur;

      // Pull sources and level status of each wake pin.
      for (int i = 0; i < wake_int_pkg::NUM_WAKE; i++) begin
         wkEn[i] = wakeCfg[i].wakeEnable && !gated[i];
         next_cur.pu[i] = 1'b0;
         next_cur.pd[i] = 1'b0;
         if (!gated[i]) begin
            unique case (wakeCfg[i].pull)
               wake_int_pkg::PULL_NONE: begin
               end
               wake_int_pkg::PULL_DOWN: next_cur.pd[i] = 1'b1;
               wake_int_pkg::PULL_UP: next_cur.pu[i] = 1'b1;
               wake_int_pkg::PULL_AUTO: begin
                  next_cur.pu[i] = filtLevel[i];
                  next_cur.pd[i] = !filtLevel[i];
               end
            endcase
            next_cur.live.level[i] = filtLevel[i];
         end
      end

      // Clears come first so that a simultaneous set wins.
      if (clearWakeA) begin
         next_cur.live.wakeA = '0;
      end
      if (clearWakeB) begin
         next_cur.live.wakeB = '0;
      end
      if (clearFail) begin
         next_cur.live.fail = '0;
      end
      for (int i = 0; i < wake_int_pkg::NUM_WAKE; i++) begin
         if (filtEdge[i] && !gated[i]) begin
            next_cur.live.wakeA[i] = 1'b1;
            if (wkEn[i]) begin
               intEvent = 1'b1;
            end
         end
      end
      for (int i = 0; i < wake_int_pkg::NUM_GPIO_WAKE; i++) begin
         if (gpioWakeEvent[i]) begin
            next_cur.live.wakeB[i] = 1'b1;
            if (gpioWakeEnable[i]) begin
               intEvent = 1'b1;
            end
         end
      end
      for (int i = 0; i < wake_int_pkg::NUM_FAIL; i++) begin
         if (failEvent[i]) begin
            next_cur.live.fail[i] = 1'b1;
            if (interruptClassSelect && failIntCapable[i]) begin
               intEvent = 1'b1;
            end
         end
      end
      anyWake = (|cur.live.wakeA) || (|cur.live.wakeB);

      // Operating mode transitions.
      onlyMeasSrc = voltageMeasureEnable && onlyMeasured(wakeCfg, gpioWakeEnable);
      next_cur.cmdFault = 1'b0;
      unique case (cur.mode)
         wake_int_pkg::MODE_INIT: begin
            if (initDone) begin
               next_cur.mode = wake_int_pkg::MODE_NORMAL;
            end
         end
         wake_int_pkg::MODE_NORMAL, wake_int_pkg::MODE_STOP: begin
            if (modeCommand == wake_int_pkg::CMD_SLEEP) begin
               if (onlyMeasSrc) begin
                  next_cur.cmdFault = 1'b1;
                  next_cur.mode = wake_int_pkg::MODE_RESTART;
               end else begin
                  next_cur.mode = wake_int_pkg::MODE_SLEEP;
               end
            end else if (modeCommand == wake_int_pkg::CMD_STOP) begin
               next_cur.mode = wake_int_pkg::MODE_STOP;
               if (anyWake) begin
                  intEvent = 1'b1;
               end
            end else if (modeCommand == wake_int_pkg::CMD_NORMAL) begin
               next_cur.mode = wake_int_pkg::MODE_NORMAL;
            end
         end
         wake_int_pkg::MODE_SLEEP, wake_int_pkg::MODE_RESTART: begin
            if (modeCommand == wake_int_pkg::CMD_NORMAL || (|filtEdge)) begin
               next_cur.mode = wake_int_pkg::MODE_NORMAL;
            end
         end
         default: next_cur.mode = wake_int_pkg::MODE_RESTART;
      endcase

      // The path switch follows the enable and the present mode.
      next_cur.switchOn = voltageMeasureEnable
         && (cur.mode == wake_int_pkg::MODE_NORMAL);

      if (!isActiveMode(cur.mode)) begin
         intEvent = 1'b0;
      end
      if (intEvent) begin
         next_cur.intPending = 1'b1;
      end

      // Interrupt timing never touches the mode field.
      next_cur.intLine = 1'b1;
      next_cur.intDrive = (cur.mode != wake_int_pkg::MODE_INIT);
      if (cur.mode == wake_int_pkg::MODE_INIT) begin
         next_cur.cfgSel = interruptPinIn;
      end
      unique case (cur.intState)
         wake_int_pkg::INT_IDLE: begin
            // Pending events wait while the mode allows no pulse.
            if (cur.intPending && isActiveMode(cur.mode)) begin
               next_cur.intPending = intEvent;
               next_cur.intState = wake_int_pkg::INT_PULSE;
               next_cur.timer = '0;
               next_cur.intLine = 1'b0;
               next_cur.snap = cur.live;
            end
         end
         wake_int_pkg::INT_PULSE: begin
            next_cur.intLine = 1'b0;
            if (timerDone(cur.timer, wake_int_pkg::PULSE_CYC)) begin
               next_cur.intLine = 1'b1;
               next_cur.intState = wake_int_pkg::INT_GAP;
               next_cur.timer = '0;
            end else begin
               next_cur.timer = cur.timer + 1'b1;
            end
         end
         wake_int_pkg::INT_GAP: begin
            if (timerDone(cur.timer, wake_int_pkg::GAP_CYC)) begin
               next_cur.intState = wake_int_pkg::INT_IDLE;
               next_cur.timer = '0;
            end else begin
               next_cur.timer = cur.timer + 1'b1;
            end
         end
         default: begin
            next_cur.intState = wake_int_pkg::INT_IDLE;
            next_cur.timer = '0;
         end
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cur <= '0;
         cur.mode <= wake_int_pkg::MODE_INIT;
         cur.intState <= wake_int_pkg::INT_IDLE;
         cur.intLine <= 1'b1;
         cur.switchOn <= 1'b0;
      end else begin
         cur <= next_cur;
      end
   end

   assign interruptOutput = cur.intLine;
   assign interruptOutputEnable = cur.intDrive;
   assign measurePathSwitch = cur.switchOn;
   assign pullUpOn = cur.pu;
   assign pullDownOn = cur.pd;
   assign statusRead = cur.snap;
   assign commandFaultFlag = cur.cmdFault;
   assign sbcMode = cur.mode;
   assign configSelect = cur.cfgSel;

endmodule
`default_nettype wire

// *** dv/wake_int_assertions.sv ***
// Port checks of the wake interrupt and measure gate block.
`timescale 1ns/1ps
`default_nettype none
module wake_int_assertions (
   input wire logic clk,
   input wire logic rst,
   input wire logic interruptOutput,
   input wire logic interruptOutputEnable,
   input wire logic measurePathSwitch,
   input wire logic voltageMeasureEnable,
   input wire logic [1:0] gpioWakeEnable,
   input wire wake_int_pkg::wake_cfg_s [2:0] wakeCfg,
   input wire logic [2:0] modeCommand,
   input wire logic [2:0] pullUpOn,
   input wire logic [2:0] pullDownOn,
   input wire wake_int_pkg::status_s statusRead,
   input wire logic commandFaultFlag,
   input wire wake_int_pkg::sbc_mode_e sbcMode
);
   logic [11:0] lowCnt;
   logic [11:0] highCnt;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // Counts the cycles of the present low stretch of the line, and of the high stretch up to GAP_CYC.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         lowCnt <= 12'h000;
         highCnt <= 12'(wake_int_pkg::GAP_CYC);
      end else begin
         lowCnt <= interruptOutput ? 12'h000 : lowCnt + 12'h001;
         if (!interruptOutput) begin
            highCnt <= 12'h000;
         end else if (highCnt < 12'(wake_int_pkg::GAP_CYC)) begin
            highCnt <= highCnt + 12'h001;
         end
      end
   end
   sequence pulseStart;
      $fell(interruptOutput);
   endsequence
   sequence pulseEnd;
      $rose(interruptOutput);
   endsequence
   sequence gatedSleep;
      modeCommand == wake_int_pkg::CMD_SLEEP && voltageMeasureEnable
      && sbcMode == wake_int_pkg::MODE_NORMAL && gpioWakeEnable == 2'h0
      && (wakeCfg[0].wakeEnable || wakeCfg[1].wakeEnable) && !wakeCfg[2].wakeEnable;
   endsequence
   AST_SWITCH_CAUSE: assert property (measurePathSwitch ==
      ($past(voltageMeasureEnable) && $past(sbcMode) == wake_int_pkg::MODE_NORMAL))
      else $error("path switch state does not follow enable and mode");
   AST_PULSE_WIDTH: assert property (pulseEnd |-> lowCnt == wake_int_pkg::PULSE_CYC)
      else $error("interrupt pulse has wrong width");
   AST_PULSE_MAX: assert property (lowCnt <= wake_int_pkg::PULSE_CYC)
      else $error("interrupt line held low too long");
   AST_GAP_MIN: assert property (pulseStart |-> highCnt >= wake_int_pkg::GAP_CYC)
      else $error("interrupt gap too short");
   AST_PULSE_MODE: assert property (pulseStart |-> $past(sbcMode) inside
      {wake_int_pkg::MODE_NORMAL, wake_int_pkg::MODE_STOP})
      else $error("interrupt pulse outside normal or stop");
   AST_MODE_HOLD: assert property (!interruptOutput && $past(modeCommand) == 3'h0
      && $past(sbcMode) inside {wake_int_pkg::MODE_NORMAL, wake_int_pkg::MODE_STOP}
      |-> $stable(sbcMode)) else $error("mode changed during pulse");
   AST_SLEEP_FAULT: assert property (gatedSleep |=> commandFaultFlag
      && sbcMode == wake_int_pkg::MODE_RESTART) else $error("gated sleep not refused");
   AST_FAULT_CAUSE: assert property (commandFaultFlag |->
      $past(modeCommand) == wake_int_pkg::CMD_SLEEP) else $error("fault flag without sleep");
   AST_PULLS_OFF: assert property (voltageMeasureEnable && $past(voltageMeasureEnable)
      |-> pullUpOn[1:0] == 2'h0 && pullDownOn[1:0] == 2'h0) else $error("pull on while gated");
   AST_SNAPSHOT: assert property ($changed(statusRead) |-> $fell(interruptOutput))
      else $error("status snapshot changed off a falling edge");
   AST_INIT_INPUT: assert property (sbcMode == wake_int_pkg::MODE_INIT
      |-> !interruptOutputEnable && interruptOutput) else $error("pin driven in init");
endmodule
bind wake_interrupt_and_measure_gate wake_int_assertions u_wake_int_assertions (
   .clk(clk), .rst(rst), .interruptOutput(interruptOutput),
   .interruptOutputEnable(interruptOutputEnable), .measurePathSwitch(measurePathSwitch),
   .voltageMeasureEnable(voltageMeasureEnable), .gpioWakeEnable(gpioWakeEnable),
   .wakeCfg(wakeCfg), .modeCommand(modeCommand), .pullUpOn(pullUpOn),
   .pullDownOn(pullDownOn), .statusRead(statusRead),
   .commandFaultFlag(commandFaultFlag), .sbcMode(sbcMode));
`default_nettype wire

// *** dv/host_model.sv ***
// Host that clears the status groups shortly after each interrupt pulse ends.
`timescale 1ns/1ps
`default_nettype none
module host_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic intLine,
   input wire logic autoClear,
   output logic clearWakeA,
   output logic clearWakeB,
   output logic clearFail
);
   logic lastInt;
   logic [1:0] delay;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         lastInt <= 1'b1;
         delay <= 2'h0;
         clearWakeA <= 1'b0;
         clearWakeB <= 1'b0;
         clearFail <= 1'b0;
      end else begin
         lastInt <= intLine;
         clearWakeA <= delay == 2'h1;
         clearWakeB <= delay == 2'h1;
         clearFail <= delay == 2'h1;
         if (autoClear && intLine && !lastInt) begin
            delay <= 2'h3;
         end else if (delay != 2'h0) begin
            delay <= delay - 2'h1;
         end
      end
   end
endmodule
`default_nettype wire

// *** dv/wake_interrupt_and_measure_gate_tb.sv ***
// Self-checking bench of the wake interrupt and measure gate block.
`timescale 1ns/1ps
`default_nettype none
module wake_interrupt_and_measure_gate_tb;
   localparam int LIMIT = 50000;
   logic clk;
   logic rst;
   logic [2:0] wakePin;
   logic [1:0] gpioWakeEvent;
   logic [1:0] gpioWakeEnable;
   wake_int_pkg::wake_cfg_s [2:0] wakeCfg;
   logic voltageMeasureEnable;
   logic interruptClassSelect;
   logic [7:0] failEvent;
   logic [7:0] failIntCapable;
   logic [2:0] modeCommand;
   logic initDone;
   logic clearWakeA;
   logic clearWakeB;
   logic clearFail;
   wire logic interruptPinIn;
   logic interruptOutput;
   logic interruptOutputEnable;
   logic measurePathSwitch;
   logic [2:0] pullUpOn;
   logic [2:0] pullDownOn;
   wake_int_pkg::status_s statusRead;
   logic commandFaultFlag;
   wake_int_pkg::sbc_mode_e sbcMode;
   logic configSelect;
   logic autoClear;
   int fails = 0;
   int checkCount = 0;
   int cycles = 0;
   int n;
   int len;
   // The pin floats high through an outside pull-up when nobody drives it.
   assign interruptPinIn = interruptOutputEnable ? interruptOutput : 1'b1;
   wake_interrupt_and_measure_gate u_wake_interrupt_and_measure_gate (.clk, .rst, .wakePin,
      .gpioWakeEvent, .gpioWakeEnable, .wakeCfg, .voltageMeasureEnable, .interruptClassSelect,
      .failEvent, .failIntCapable, .modeCommand, .initDone, .clearWakeA, .clearWakeB,
      .clearFail, .interruptPinIn, .interruptOutput, .interruptOutputEnable,
      .measurePathSwitch, .pullUpOn, .pullDownOn, .statusRead, .commandFaultFlag, .sbcMode,
      .configSelect);
   host_model u_host_model (.clk, .rst, .intLine(interruptOutput), .autoClear, .clearWakeA,
      .clearWakeB, .clearFail);
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task check(input logic [31:0] seen, input logic [31:0] exp);
      checkCount = checkCount + 1;
      if (seen !== exp) begin
         fails = fails + 1;
         $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   task complete_run;
      $display("checks %0d mismatches %0d", checkCount, fails);
      if (fails == 0 && checkCount > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task cyc(input int c);
      repeat (c) @(negedge clk);
   endtask
   // Counts falling edges while the interrupt line keeps level v, up to lim.
   task span(input logic v, input int lim, output int c);
      c = 0;
      while (interruptOutput === v && c < lim) begin
         @(negedge clk);
         c = c + 1;
      end
   endtask
   task fire(input logic [1:0] g, input logic [7:0] f);
      gpioWakeEvent = g;
      failEvent = f;
      @(negedge clk);
      gpioWakeEvent = 2'h0;
      failEvent = 8'h00;
   endtask
   task cmd(input logic [2:0] c);
      modeCommand = c;
      @(negedge clk);
      modeCommand = wake_int_pkg::CMD_NONE;
   endtask
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         fails = fails + 1;
         complete_run();
      end
   end
   initial begin
      rst = 1'b1;
      wakePin = 3'h0;
      gpioWakeEvent = 2'h0;
      gpioWakeEnable = 2'h0;
      wakeCfg = '0;
      voltageMeasureEnable = 1'b0;
      interruptClassSelect = 1'b1;
      failEvent = 8'h00;
      failIntCapable = 8'hFE;
      modeCommand = wake_int_pkg::CMD_NONE;
      initDone = 1'b0;
      autoClear = 1'b0;
      cyc(12);
      rst = 1'b0;
      cyc(300);
      check(measurePathSwitch, 0);
      check(interruptOutputEnable, 0);
      check(configSelect, 1);
      initDone = 1'b1;
      cyc(3);
      check(sbcMode, wake_int_pkg::MODE_NORMAL);
      check(interruptOutputEnable, 1);
      fire(2'h0, 8'h01);
      span(1'b1, 60, n);
      check(n, 60);
      fire(2'h0, 8'h02);
      span(1'b1, 10, n);
      check(n, 1);
      check(statusRead.fail, 8'h03);
      gpioWakeEnable = 2'h1;
      cyc(100);
      fire(2'h1, 8'h02);
      span(1'b0, 3000, n);
      span(1'b1, 5000, n);
      check(n >= wake_int_pkg::GAP_CYC && n <= wake_int_pkg::GAP_CYC + 3, 1);
      check(statusRead.wakeB, 2'h1);
      span(1'b0, 3000, n);
      check(n, wake_int_pkg::PULSE_CYC);
      span(1'b1, 4100, n);
      check(n, 4100);
      gpioWakeEnable = 2'h0;
      fire(2'h1, 8'h00);
      span(1'b1, 60, n);
      check(n, 60);
      wakeCfg[2].wakeEnable = 1'b1;
      for (int k = 0; k < 2; k++) begin
         len = (k == 1) ? wake_int_pkg::LONG_FILTER_CYC : wake_int_pkg::SHORT_FILTER_CYC;
         wakeCfg[2].filter = (k == 1) ? wake_int_pkg::FILT_STATIC_LONG : 2'h0;
         wakePin[2] = ~wakePin[2];
         cyc(len - 10);
         wakePin[2] = ~wakePin[2];
         span(1'b1, len + 20, n);
         check(n, len + 20);
         wakePin[2] = ~wakePin[2];
         span(1'b1, len + 20, n);
         check(n >= len && n <= len + 6, 1);
         cyc(4100);
      end
      wakeCfg[2].wakeEnable = 1'b0;
      cmd(wake_int_pkg::CMD_STOP);
      span(1'b1, 10, n);
      check(n <= 4, 1);
      check(sbcMode, wake_int_pkg::MODE_STOP);
      cyc(4100);
      cmd(wake_int_pkg::CMD_NORMAL);
      autoClear = 1'b1;
      gpioWakeEnable = 2'h1;
      fire(2'h1, 8'h00);
      cyc(4100);
      cmd(wake_int_pkg::CMD_STOP);
      span(1'b1, 60, n);
      check(n, 60);
      cmd(wake_int_pkg::CMD_NORMAL);
      gpioWakeEnable = 2'h0;
      wakeCfg[0] = '{wake_int_pkg::PULL_UP, 2'h0, 1'b1};
      cyc(3);
      check(pullUpOn[0], 1);
      voltageMeasureEnable = 1'b1;
      cyc(3);
      check(measurePathSwitch, 1);
      check({pullUpOn[1:0], pullDownOn[1:0]}, 0);
      wakePin[1:0] = 2'h3;
      span(1'b1, 400, n);
      check(n, 400);
      wakePin[1:0] = 2'h0;
      cyc(400);
      cmd(wake_int_pkg::CMD_SLEEP);
      check(commandFaultFlag, 1);
      check(sbcMode, wake_int_pkg::MODE_RESTART);
      cyc(2);
      check(measurePathSwitch, 0);
      voltageMeasureEnable = 1'b0;
      cmd(wake_int_pkg::CMD_NORMAL);
      cyc(3);
      check(pullUpOn[0], 1);
      interruptClassSelect = 1'b0;
      cyc(4100);
      fire(2'h0, 8'h02);
      span(1'b1, 60, n);
      check(n, 60);
      complete_run();
   end
endmodule
`default_nettype wire
